// File: src/tuner_synth_i2c_control.sv
`timescale 1ns/1ps
module tuner_synth_i2c_control
    import tuner_synth_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic lo_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic ref_in,
    input wire logic [7:0] port_lines_in,
    input wire logic [1:0] var_addr_in,
    input wire logic [2:0] adc_level_in,
    output logic [7:0] port_lines_oe_out,
    output logic pump_up_out,
    output logic pump_down_out,
    output logic pump_current_select_out,
    output logic varactor_drive_off_out,
    output logic lock_flag_out
);
    logic scl_s, sda_s, ref_s, fdiv_s, fdiv_lo, lock_ff;
    logic [2:0] pin_bits_s;
    logic [2:0] adc_s;
    logic [1:0] var_addr_s;

    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    sync_2ff #(.W(11)) u_pin_sync (
        .clk_in(mclk_in),
        .d_in({scl_in, sda_in, ref_in, port_lines_in[7], port_lines_in[5],
               port_lines_in[4], adc_level_in, var_addr_in}),
        .q_out({scl_s, sda_s, ref_s, pin_bits_s, adc_s, var_addr_s})
    );

    sync_2ff #(.W(1)) u_fdiv_sync (
        .clk_in(mclk_in),
        .d_in(fdiv_lo),
        .q_out(fdiv_s)
    );

    // Bus framing
    logic scl_d_ff, sda_d_ff;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign start_cond = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_cond = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    bus_state_e state_ff, nxt_state;
    byte_class_e expect_ff, nxt_expect;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic rd_mode_ff, nxt_rd_mode;
    logic mack_ff, nxt_mack;
    logic oe_ff, nxt_oe;
    logic por_ff, nxt_por;
    logic [DIV_W-1:0] divider_ratio_ff, nxt_divider_ratio;
    pump_ctrl_s pump_ctrl_ff, nxt_pump_ctrl;
    logic [7:0] port_ctrl_ff, nxt_port_ctrl;
    logic req_tgl_ff, nxt_req_tgl;
    logic byte_done;
    logic addr_match;
    status_s status;

    assign byte_done = (state_ff == ST_RX) && scl_fall && (bit_cnt_ff == BITS_PER_BYTE);
    assign addr_match = (shift_ff[7:3] == ADDR_CONST)
        && ((shift_ff[2:1] == var_addr_s) || (shift_ff[2:1] == ADDR_VAR_ALWAYS));
    assign status = '{por: por_ff, lock_flag: lock_ff, port_bits: pin_bits_s,
                      adc_bits: adc_s};

    always_comb begin
        nxt_state = state_ff;
        nxt_expect = expect_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_rd_mode = rd_mode_ff;
        nxt_mack = mack_ff;
        nxt_oe = oe_ff;
        nxt_por = por_ff;
        nxt_divider_ratio = divider_ratio_ff;
        nxt_pump_ctrl = pump_ctrl_ff;
        nxt_port_ctrl = port_ctrl_ff;
        nxt_req_tgl = req_tgl_ff;
        if (stop_cond) begin
            nxt_state = ST_IDLE;
            nxt_oe = 1'b0;
            if (rd_mode_ff && state_ff != ST_IDLE) begin
                nxt_por = 1'b0;
            end
            nxt_rd_mode = 1'b0;
        end else if (start_cond) begin
            nxt_state = ST_ADDR;
            nxt_bit_cnt = 4'h0;
            nxt_oe = 1'b0;
            nxt_expect = EXP_FIRST;
            nxt_rd_mode = 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE, ST_IGNORE: begin
                    nxt_oe = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise && bit_cnt_ff != BITS_PER_BYTE) begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end
                    if (scl_fall && bit_cnt_ff == BITS_PER_BYTE) begin
                        nxt_bit_cnt = 4'h0;
                        if (state_ff == ST_RX) begin
                            nxt_state = ST_ACK;
                            nxt_oe = 1'b1;
                            unique case (expect_ff)
                                EXP_FIRST: begin
                                    if (!shift_ff[CLASS_BIT]) begin
                                        nxt_divider_ratio[DIV_W-1:8] = shift_ff[6:0];
                                        nxt_req_tgl = ~req_tgl_ff;
                                        nxt_expect = EXP_DIV_LO;
                                    end else begin
                                        nxt_pump_ctrl.pump_current_select =
                                            shift_ff[PUMP_CUR_BIT];
                                        nxt_pump_ctrl.test_mode_select =
                                            shift_ff[TEST_BIT];
                                        nxt_pump_ctrl.pump_disable =
                                            shift_ff[PUMP_DIS_BIT];
                                        nxt_pump_ctrl.varactor_drive_off =
                                            shift_ff[VAR_OFF_BIT];
                                        nxt_expect = EXP_PORTS;
                                    end
                                end
                                EXP_DIV_LO: begin
                                    nxt_divider_ratio[7:0] = shift_ff;
                                    nxt_req_tgl = ~req_tgl_ff;
                                    nxt_expect = EXP_FIRST;
                                end
                                EXP_PORTS: begin
                                    nxt_port_ctrl = shift_ff;
                                    nxt_expect = EXP_FIRST;
                                end
                                default: nxt_expect = EXP_FIRST;
                            endcase
                        end else if (addr_match) begin
                            nxt_state = ST_ACK;
                            nxt_oe = 1'b1;
                            nxt_rd_mode = shift_ff[ADDR_RW_BIT];
                        end else begin
                            nxt_state = ST_IGNORE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (rd_mode_ff) begin
                            nxt_state = ST_TX;
                            nxt_shift = status;
                            nxt_oe = ~status[7];
                            nxt_bit_cnt = 4'h1;
                        end else begin
                            nxt_state = ST_RX;
                            nxt_oe = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_ff == BITS_PER_BYTE) begin
                            nxt_state = ST_MACK;
                            nxt_oe = 1'b0;
                            nxt_mack = 1'b0;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_oe = ~shift_ff[6];
                            nxt_bit_cnt = bit_cnt_ff + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        nxt_mack = ~sda_s;
                    end
                    if (scl_fall) begin
                        if (mack_ff) begin
                            nxt_state = ST_TX;
                            nxt_shift = status;
                            nxt_oe = ~status[7];
                            nxt_bit_cnt = 4'h1;
                        end else begin
                            nxt_state = ST_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            state_ff <= ST_IDLE;
            expect_ff <= EXP_FIRST;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            rd_mode_ff <= 1'b0;
            mack_ff <= 1'b0;
            oe_ff <= 1'b0;
            por_ff <= 1'b1;
            divider_ratio_ff <= DIV_RESET;
            pump_ctrl_ff <= '0;
            port_ctrl_ff <= PORT_RESET;
            req_tgl_ff <= 1'b0;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            state_ff <= nxt_state;
            expect_ff <= nxt_expect;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            rd_mode_ff <= nxt_rd_mode;
            mack_ff <= nxt_mack;
            oe_ff <= nxt_oe;
            por_ff <= nxt_por;
            divider_ratio_ff <= nxt_divider_ratio;
            pump_ctrl_ff <= nxt_pump_ctrl;
            port_ctrl_ff <= nxt_port_ctrl;
            req_tgl_ff <= nxt_req_tgl;
        end
    end

    lo_divider u_lo_divider (
        .lo_clk_in(lo_clk_in),
        .lo_rstn_in(rstn_in),
        .ratio_in(divider_ratio_ff),
        .req_tgl_in(req_tgl_ff),
        .fdiv_out(fdiv_lo)
    );

    // Reference divider, phase comparator and lock detect
    logic ref_d_ff, comp_ff, comp_d_ff, fdiv_d_ff;
    logic [REF_CNT_W-1:0] ref_cnt_ff, nxt_ref_cnt;
    logic [1:0] edge_cnt_ff, nxt_edge_cnt;
    logic [2:0] good_cnt_ff, nxt_good_cnt;
    logic nxt_lock;
    logic up_ff, nxt_up, dn_ff, nxt_dn;
    logic pump_up_ff, pump_dn_ff;
    logic [7:0] port_oe_ff, nxt_port_oe;
    logic comp_rise, fdiv_rise;

    assign comp_rise = comp_ff & ~comp_d_ff;
    assign fdiv_rise = fdiv_s & ~fdiv_d_ff;

    always_comb begin
        nxt_ref_cnt = (ref_s & ~ref_d_ff) ? ref_cnt_ff + 1'b1 : ref_cnt_ff;
        nxt_edge_cnt = edge_cnt_ff;
        nxt_good_cnt = good_cnt_ff;
        nxt_lock = lock_ff;
        if (comp_rise) begin
            nxt_edge_cnt = {1'b0, fdiv_rise};
            if (edge_cnt_ff == 2'h1) begin
                nxt_good_cnt = (good_cnt_ff == 3'(LOCK_PERIODS)) ? good_cnt_ff
                    : good_cnt_ff + 3'h1;
            end else begin
                nxt_good_cnt = 3'h0;
            end
            nxt_lock = (nxt_good_cnt == 3'(LOCK_PERIODS));
        end else if (fdiv_rise && edge_cnt_ff != 2'h3) begin
            nxt_edge_cnt = edge_cnt_ff + 2'h1;
        end
        nxt_up = (up_ff | comp_rise) & ~(dn_ff | fdiv_rise);
        nxt_dn = (dn_ff | fdiv_rise) & ~(up_ff | comp_rise);
        nxt_port_oe = port_ctrl_ff;
        if (pump_ctrl_ff.test_mode_select) begin
            nxt_port_oe[PORT_SIX] = ~comp_ff;
            nxt_port_oe[PORT_SEVEN] = ~fdiv_s;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            ref_d_ff <= 1'b0;
            ref_cnt_ff <= '0;
            comp_ff <= 1'b0;
            comp_d_ff <= 1'b0;
            fdiv_d_ff <= 1'b0;
            edge_cnt_ff <= 2'h0;
            good_cnt_ff <= 3'h0;
            lock_ff <= 1'b0;
            up_ff <= 1'b0;
            dn_ff <= 1'b0;
            pump_up_ff <= 1'b0;
            pump_dn_ff <= 1'b0;
            port_oe_ff <= PORT_RESET;
        end else begin
            ref_d_ff <= ref_s;
            ref_cnt_ff <= nxt_ref_cnt;
            comp_ff <= ref_cnt_ff[REF_CNT_W-1];
            comp_d_ff <= comp_ff;
            fdiv_d_ff <= fdiv_s;
            edge_cnt_ff <= nxt_edge_cnt;
            good_cnt_ff <= nxt_good_cnt;
            lock_ff <= nxt_lock;
            up_ff <= nxt_up;
            dn_ff <= nxt_dn;
            pump_up_ff <= nxt_up & ~pump_ctrl_ff.pump_disable;
            pump_dn_ff <= nxt_dn & ~pump_ctrl_ff.pump_disable;
            port_oe_ff <= nxt_port_oe;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_ff;
    assign port_lines_oe_out = port_oe_ff;
    assign pump_up_out = pump_up_ff;
    assign pump_down_out = pump_dn_ff;
    assign pump_current_select_out = pump_ctrl_ff.pump_current_select;
    assign varactor_drive_off_out = pump_ctrl_ff.varactor_drive_off;
    assign lock_flag_out = lock_ff;

    AST_ADDR_ACK: assert property (state_ff == ST_ADDR && scl_fall && addr_match
        && bit_cnt_ff == BITS_PER_BYTE && !start_cond && !stop_cond
        |=> oe_ff && state_ff == ST_ACK) else $error("address not acknowledged");
    AST_FOREIGN: assert property (state_ff == ST_ADDR && scl_fall && !addr_match
        && bit_cnt_ff == BITS_PER_BYTE && !start_cond && !stop_cond
        |=> !oe_ff && state_ff == ST_IGNORE) else $error("foreign address answered");
    AST_READ_DIR: assert property (state_ff == ST_ACK && rd_mode_ff && scl_fall
        && !stop_cond && !start_cond |=> state_ff == ST_TX && shift_ff == $past(status))
        else $error("read mode did not load status");
    AST_CLASS: assert property (byte_done && expect_ff == EXP_FIRST
        && !shift_ff[CLASS_BIT] && !stop_cond && !start_cond
        |=> expect_ff == EXP_DIV_LO) else $error("frequency byte misclassified");
    AST_DIV_LO: assert property (byte_done && expect_ff == EXP_DIV_LO
        && !stop_cond && !start_cond |=> divider_ratio_ff[7:0] == $past(shift_ff)
        && expect_ff == EXP_FIRST) else $error("lower divider byte not stored");
    AST_PARTIAL: assert property ((stop_cond || start_cond)
        |=> $stable(divider_ratio_ff) && $stable(port_ctrl_ff))
        else $error("partial byte changed settings");
    AST_POR: assert property (stop_cond && rd_mode_ff && state_ff != ST_IDLE
        |=> !por_ff) else $error("power-on flag not cleared");
    AST_PUMP_DIS: assert property (pump_ctrl_ff.pump_disable
        && $past(pump_ctrl_ff.pump_disable) |-> !pump_up_ff && !pump_dn_ff)
        else $error("pump active while disabled");
    AST_TEST: assert property (pump_ctrl_ff.test_mode_select
        |=> port_oe_ff[PORT_SIX] == !$past(comp_ff))
        else $error("test signal missing on port six");
    AST_PORTS: assert property (!pump_ctrl_ff.test_mode_select
        |=> port_oe_ff == $past(port_ctrl_ff)) else $error("port state not applied");
    AST_COMP: assert property ($rose(comp_ff) |=> comp_ff [*2])
        else $error("comparison clock too short");
endmodule : tuner_synth_i2c_control

// File: src/tuner_synth_pkg.sv
package tuner_synth_pkg;
    // Bus address: constant upper bits, two variable bits, direction bit
    localparam logic [4:0] ADDR_CONST = 5'h18;
    localparam logic [1:0] ADDR_VAR_ALWAYS = 2'h1;
    localparam int ADDR_RW_BIT = 0;
    // Data byte fields, bit 7 is sent first
    localparam int CLASS_BIT = 7;
    localparam int PUMP_CUR_BIT = 6;
    localparam int TEST_BIT = 5;
    localparam int PUMP_DIS_BIT = 4;
    localparam int VAR_OFF_BIT = 0;
    localparam int PORT_SIX = 6;
    localparam int PORT_SEVEN = 7;
    localparam int DIV_W = 15;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Reset values: ports off, pump low current, divider zero
    localparam logic [DIV_W-1:0] DIV_RESET = 15'h0000;
    localparam logic [7:0] PORT_RESET = 8'h00;
    // Reference and loop dividers
    localparam int REF_HZ = 4000000;
    localparam int REF_DIV = 512;
    localparam int COMP_HZ = REF_HZ / REF_DIV;
    localparam int REF_CNT_W = $clog2(REF_DIV);
    localparam int PRESCALE = 8;
    localparam int LOCK_PERIODS = 4;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK, ST_IGNORE
    } bus_state_e;

    typedef enum logic [1:0] {EXP_FIRST, EXP_DIV_LO, EXP_PORTS} byte_class_e;

    typedef struct packed {
        logic pump_current_select;
        logic test_mode_select;
        logic pump_disable;
        logic varactor_drive_off;
    } pump_ctrl_s;

    typedef struct packed {
        logic por;
        logic lock_flag;
        logic [2:0] port_bits;
        logic [2:0] adc_bits;
    } status_s;
endpackage : tuner_synth_pkg

// File: src/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;

    always_ff @(posedge clk_in) begin
        meta_ff <= d_in;
        hold_ff <= meta_ff;
    end

    assign q_out = hold_ff;
endmodule : sync_2ff

// File: src/lo_divider.sv
`timescale 1ns/1ps
module lo_divider
    import tuner_synth_pkg::*;
(
    input wire logic lo_clk_in,
    input wire logic lo_rstn_in,
    input wire logic [DIV_W-1:0] ratio_in,
    input wire logic req_tgl_in,
    output logic fdiv_out
);
    logic [2:0] pre_ff, nxt_pre;
    logic [DIV_W-1:0] cnt_ff, nxt_cnt;
    logic [DIV_W-1:0] ratio_ff, nxt_ratio;
    logic tgl_d_ff, nxt_tgl_d;
    logic fdiv_ff, nxt_fdiv;
    logic rstn_s, tgl_s;

    // Reset and update toggle enter this domain; ratio word is stable when toggle seen
    sync_2ff #(.W(2)) u_lo_sync (
        .clk_in(lo_clk_in),
        .d_in({lo_rstn_in, req_tgl_in}),
        .q_out({rstn_s, tgl_s})
    );

    // Prescaler by eight feeds the programmable divider
    always_comb begin
        nxt_pre = pre_ff + 3'h1;
        nxt_tgl_d = tgl_s;
        nxt_ratio = (tgl_s != tgl_d_ff) ? ratio_in : ratio_ff;
        nxt_cnt = cnt_ff;
        nxt_fdiv = fdiv_ff;
        if (pre_ff == 3'(PRESCALE - 1)) begin
            nxt_cnt = (cnt_ff >= ratio_ff - 15'h0001) ? 15'h0000 : cnt_ff + 15'h0001;
            nxt_fdiv = (nxt_cnt < (ratio_ff >> 1));
        end
    end

    always_ff @(posedge lo_clk_in) begin
        if (!rstn_s) begin
            pre_ff <= 3'h0;
            cnt_ff <= DIV_RESET;
            ratio_ff <= DIV_RESET;
            tgl_d_ff <= 1'b0;
            fdiv_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            cnt_ff <= nxt_cnt;
            ratio_ff <= nxt_ratio;
            tgl_d_ff <= nxt_tgl_d;
            fdiv_ff <= nxt_fdiv;
        end
    end

    assign fdiv_out = fdiv_ff;
endmodule : lo_divider

// File: testbench/i2c_ctrl_model.sv
`timescale 1ns/1ps
module i2c_ctrl_model (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic hp;
        repeat (8) @(posedge mclk_in);
    endtask : hp
    // Start or repeated start
    task automatic start;
        hp;
        sda_oe_out <= 1'b0;
        hp;
        scl_out <= 1'b1;
        hp;
        sda_oe_out <= 1'b1;
        hp;
        scl_out <= 1'b0;
    endtask : start
    task automatic stop;
        hp;
        sda_oe_out <= 1'b1;
        hp;
        scl_out <= 1'b1;
        hp;
        sda_oe_out <= 1'b0;
        hp;
    endtask : stop
    // Data set while clock low, sampled at end of high phase
    task automatic bit_io(input logic b, output logic r);
        hp;
        sda_oe_out <= ~b;
        hp;
        scl_out <= 1'b1;
        hp;
        r = sda_in;
        scl_out <= 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                        output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(mack, a);
    endtask : xfer
endmodule : i2c_ctrl_model

// File: testbench/tb_tuner_synth_i2c_control.sv
`timescale 1ns/1ps
module tb_tuner_synth_i2c_control;
    import tuner_synth_pkg::*;
    logic mclk_in = 0, rstn_in = 0, lo_clk_in = 0, ref_in = 0;
    logic scl, m_oe, sda_out, sda_oe_out, sda;
    logic [7:0] port_lines_in = 8'h00, port_lines_oe_out, rd, pt, exp_port;
    logic [1:0] var_addr_in = 2'h1;
    logic [2:0] adc_level_in = 3'h0;
    logic pump_up_out, pump_down_out, pump_current_select_out;
    logic varactor_drive_off_out, lock_flag_out, ak, cp, os, bad;
    integer seed = 32'h58B5;
    int n_fail = 0, num_checks = 0, cyc = 0, exp_por = 1, tgl = 0;
    assign sda = ~(m_oe | sda_oe_out); // Pull-up
    always #5 mclk_in = ~mclk_in;
    always #7.5 lo_clk_in = ~lo_clk_in;
    always #125 ref_in = ~ref_in;
    tuner_synth_i2c_control dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .lo_clk_in(lo_clk_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .ref_in(ref_in), .port_lines_in(port_lines_in),
        .var_addr_in(var_addr_in), .adc_level_in(adc_level_in),
        .port_lines_oe_out(port_lines_oe_out), .pump_up_out(pump_up_out),
        .pump_down_out(pump_down_out), .pump_current_select_out(pump_current_select_out),
        .varactor_drive_off_out(varactor_drive_off_out), .lock_flag_out(lock_flag_out));
    i2c_ctrl_model m (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
    task automatic results;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            results;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] d);
        m.xfer(d, 1'b1, rd, ak);
        chk({7'h0, ak}, 8'h00);
    endtask : wr
    function automatic logic [7:0] stat();
        return {exp_por[0], lock_flag_out, port_lines_in[7], port_lines_in[5],
                port_lines_in[4], adc_level_in};
    endfunction : stat
    initial begin
        repeat (16) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (8) @(posedge mclk_in);
        chk(port_lines_oe_out, PORT_RESET);
        port_lines_in <= $random(seed);
        adc_level_in <= $random(seed);
        // Two status reads; flag cleared by the stop of the first
        for (int k = 0; k < 2; k++) begin
            m.start;
            wr(8'hC3);
            m.xfer(8'hFF, 1'b0, rd, ak);
            chk(rd, stat());
            m.xfer(8'hFF, 1'b1, rd, ak);
            chk(rd, stat());
            m.stop;
            exp_por = 0;
        end
        // Writes at every variable address
        for (int v = 0; v < 4; v++) begin
            var_addr_in <= v[1:0];
            cp = $random(seed);
            os = $random(seed);
            pt = $random(seed);
            m.start;
            wr({ADDR_CONST, v[1:0], 1'b0});
            wr({1'b1, cp, 1'b0, v[0], 3'h7, os});
            wr(pt);
            wr({1'b0, 7'($random(seed))});
            wr(8'($random(seed)));
            m.stop;
            exp_port = pt;
            chk(port_lines_oe_out, exp_port);
            chk({6'h0, pump_current_select_out, varactor_drive_off_out}, {6'h0, cp, os});
            bad = 1'b0;
            repeat (300) begin
                @(posedge mclk_in);
                if ((pump_up_out | pump_down_out) !== 1'b0) bad = 1'b1;
            end
            if (v[0]) chk({7'h0, bad}, 8'h00);
        end
        // Foreign variable bits are not acknowledged
        var_addr_in <= 2'h2;
        m.start;
        m.xfer({ADDR_CONST, 2'h3, 1'b0}, 1'b1, rd, ak);
        chk({7'h0, ak}, 8'h01);
        m.stop;
        // Port byte cut after four bits
        m.start;
        wr({ADDR_CONST, 2'h1, 1'b0});
        wr(8'h8E);
        for (int i = 7; i > 3; i--) m.bit_io(~exp_port[i], ak);
        m.stop;
        chk(port_lines_oe_out, exp_port);
        // Repeated start turning into a read
        m.start;
        wr({ADDR_CONST, 2'h1, 1'b0});
        m.start;
        wr({ADDR_CONST, 2'h1, 1'b1});
        m.xfer(8'hFF, 1'b1, rd, ak);
        chk(rd, stat());
        m.stop;
        // Test mode: comparison clock shows on port six
        m.start;
        wr({ADDR_CONST, 2'h1, 1'b0});
        wr(8'hAE);
        wr(exp_port);
        m.stop;
        chk({2'h0, port_lines_oe_out[5:0]}, {2'h0, exp_port[5:0]});
        bad = port_lines_oe_out[PORT_SIX];
        repeat (13000) begin
            @(posedge mclk_in);
            if (port_lines_oe_out[PORT_SIX] !== bad) tgl++;
            bad = port_lines_oe_out[PORT_SIX];
        end
        chk({7'h0, tgl >= 2}, 8'h01);
        results;
    end
endmodule : tb_tuner_synth_i2c_control
